// ### verilog/bfmcs_pkg.sv
// Package of offsets, reset values, field positions and carrier types for the misc control block
package bfmcs_pkg;
	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [7:0] OFS_RESET_SWITCH_STATUS = 8'h0B;
	localparam logic [7:0] OFS_MISC_PIN_CONTROL    = 8'h0C;
	localparam logic [7:0] OFS_MISC_PIN_STATUS     = 8'h0D;
	localparam logic [7:0] OFS_FW_UPDATE_ENABLE    = 8'h0E;
	localparam logic [7:0] RST_MISC_PIN_CONTROL    = 8'h1C;
	localparam logic [7:0] RST_FW_UPDATE_ENABLE    = 8'h00;
	localparam logic [7:0] FW_UPDATE_KEY           = 8'h68;
	localparam logic [7:0] CTRL_WRITE_MASK         = 8'h7F;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int BIT_RESET_STATUS  = 4;
	localparam int BIT_TRIGGER_RESET = 5;
	localparam int BIT_PCIE_SWITCH   = 6;
	localparam int BIT_USER_SWITCH   = 7;
	localparam int BIT_NAND_WP       = 2;
	localparam int BIT_MEZZ_EN       = 3;
	localparam int BIT_NOR_WP        = 4;
	localparam int BIT_EEPROM_WP     = 5;
	localparam int BIT_I2C_EN        = 6;
	localparam int BIT_FW_ENABLED    = 0;
	localparam int BIT_HOST_OUTPUT   = 2;
	localparam int BIT_SYSCLK_OUTPUT = 3;
	localparam int SYNC_WIDTH        = 6;

	// Serial port clock source select, control bits 1-0
	typedef enum logic [1:0] {
		BFMCS_SEL_CLK_A   = 2'b00,
		BFMCS_SEL_CLK_B   = 2'b01,
		BFMCS_SEL_CLK_D   = 2'b10,
		BFMCS_SEL_RELEASE = 2'b11
	} bfmcs_clk_sel_e;

	// Mirrored input levels, ordered as the synchroniser vector
	typedef struct packed {
		logic processor_system_clock_output;
		logic processor_host_output;
		logic user_board_switch;
		logic pcie_subsystem_enable_switch;
		logic trigger_reset_n;
		logic processor_reset_status_n;
	} bfmcs_mirror_s;

	// Serial port timing outputs with their shared enable
	typedef struct packed {
		logic sample_clocks;
		logic transmit_clocks;
		logic receive_clocks;
		logic transmit_frame_syncs;
		logic receive_frame_syncs;
		logic drive_enable;
	} bfmcs_sport_s;
endpackage : bfmcs_pkg

// ### verilog/bfmcs_sync.sv
// Two-stage level synchroniser for a vector of mirrored pins
`timescale 1ns/1ps
`default_nettype none
module bfmcs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_sync_out;

	// ----------------------------------------
	// Stage logic: first stage feeds only the second
	// ----------------------------------------
	always_comb begin
		next_stage_one = async_in;
		next_sync_out  = stage_one;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage_one <= '0;
			sync_out  <= '0;
		end else begin
			stage_one <= next_stage_one;
			sync_out  <= next_sync_out;
		end
	end
endmodule : bfmcs_sync
`default_nettype wire

// ### verilog/bfmcs_misc_regs.sv
// Board misc control and status byte registers with serial clock steering
`timescale 1ns/1ps
`default_nettype none
module bfmcs_misc_regs (
	input  wire logic       clk,
	input  wire logic       reset,
	// Register port, byte offsets from the register space base
	input  wire logic [7:0] reg_address,
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_write_data,
	output logic      [7:0] reg_read_data,
	output logic            reg_read_valid,
	// Mirrored levels
	input  wire logic       processor_reset_status_n,
	input  wire logic       trigger_reset_n,
	input  wire logic       pcie_subsystem_enable_switch,
	input  wire logic       user_board_switch,
	input  wire logic       processor_host_output,
	input  wire logic       processor_system_clock_output,
	// Board control outputs
	output logic            backplane_serial_port_enable_n,
	output logic            nand_write_protect,
	output logic            debug_mezzanine_enable,
	output logic            nor_write_protect,
	output logic            eeprom_write_protect,
	output logic            i2c_level_translator_enable,
	// Backplane timing clocks and serial port timing outputs
	input  wire logic       backplane_timing_clock_a,
	input  wire logic       backplane_timing_clock_b,
	input  wire logic       backplane_timing_clock_c,
	input  wire logic       backplane_timing_clock_d,
	output logic            serial_port_sample_clocks,
	output logic            serial_port_transmit_clocks,
	output logic            serial_port_receive_clocks,
	output logic            serial_port_transmit_frame_syncs,
	output logic            serial_port_receive_frame_syncs,
	output logic            serial_port_timing_oe,
	// Processor GPIO 12..15 and firmware-update serial interface
	input  wire logic [3:0] processor_gpio_in,
	output logic      [3:0] processor_gpio_out,
	output logic      [3:0] processor_gpio_oe,
	output logic            firmware_update_serial_clock,
	output logic            firmware_update_chip_select_n,
	output logic            firmware_update_serial_out,
	output logic            firmware_update_serial_oe,
	input  wire logic       firmware_update_serial_in,
	output logic            firmware_update_enabled
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	bfmcs_pkg::bfmcs_mirror_s   raw_mirror;
	bfmcs_pkg::bfmcs_mirror_s   mirror;
	bfmcs_pkg::bfmcs_clk_sel_e  clk_sel;
	bfmcs_pkg::bfmcs_sport_s    sport;
	logic [7:0]                 misc_pin_control;
	logic [7:0]                 next_misc_pin_control;
	logic [7:0]                 fw_update_enable;
	logic [7:0]                 next_fw_update_enable;
	logic [7:0]                 next_reg_read_data;
	logic                       next_reg_read_valid;
	logic                       serial_clock_src;

	// Selects a read value for one offset; unmapped offsets read zero
	function automatic logic [7:0] bfmcs_read_mux(
		input logic [7:0]               addr,
		input logic [7:0]               ctrl,
		input logic [7:0]               fw_reg,
		input bfmcs_pkg::bfmcs_mirror_s mir
	);
		logic [7:0] value;
		value = 8'h00;
		case (addr)
			bfmcs_pkg::OFS_RESET_SWITCH_STATUS: begin
				value[bfmcs_pkg::BIT_RESET_STATUS]  = mir.processor_reset_status_n;
				value[bfmcs_pkg::BIT_TRIGGER_RESET] = mir.trigger_reset_n;
				value[bfmcs_pkg::BIT_PCIE_SWITCH]   = mir.pcie_subsystem_enable_switch;
				value[bfmcs_pkg::BIT_USER_SWITCH]   = mir.user_board_switch;
			end
			bfmcs_pkg::OFS_MISC_PIN_CONTROL: begin
				value = ctrl & bfmcs_pkg::CTRL_WRITE_MASK;
			end
			bfmcs_pkg::OFS_MISC_PIN_STATUS: begin
				value[bfmcs_pkg::BIT_FW_ENABLED]    = (fw_reg == bfmcs_pkg::FW_UPDATE_KEY);
				value[bfmcs_pkg::BIT_HOST_OUTPUT]   = mir.processor_host_output;
				value[bfmcs_pkg::BIT_SYSCLK_OUTPUT] = mir.processor_system_clock_output;
			end
			bfmcs_pkg::OFS_FW_UPDATE_ENABLE: begin
				value = fw_reg;
			end
			default: begin
				value = 8'h00;
			end
		endcase
		return value;
	endfunction : bfmcs_read_mux

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Lower bits of offset 0Bh belong to another block; this slice drives only 7-4
	assign raw_mirror.processor_system_clock_output = processor_system_clock_output;
	assign raw_mirror.processor_host_output         = processor_host_output;
	assign raw_mirror.user_board_switch             = user_board_switch;
	assign raw_mirror.pcie_subsystem_enable_switch  = pcie_subsystem_enable_switch;
	assign raw_mirror.trigger_reset_n               = trigger_reset_n;
	assign raw_mirror.processor_reset_status_n      = processor_reset_status_n;

	bfmcs_sync #(
		.WIDTH    (bfmcs_pkg::SYNC_WIDTH)
	) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (raw_mirror),
		.sync_out (mirror)
	);

	// ----------------------------------------
	// Register writes and read answer
	// ----------------------------------------
	// Write decode by byte offset; read data answers one cycle after the strobe
	always_comb begin
		next_misc_pin_control = misc_pin_control;
		next_fw_update_enable = fw_update_enable;
		if (reg_write) begin
			if (reg_address == bfmcs_pkg::OFS_MISC_PIN_CONTROL) begin
				next_misc_pin_control = reg_write_data & bfmcs_pkg::CTRL_WRITE_MASK;
			end
			if (reg_address == bfmcs_pkg::OFS_FW_UPDATE_ENABLE) begin
				next_fw_update_enable = reg_write_data;
			end
		end
		next_reg_read_valid = reg_read;
		next_reg_read_data  = reg_read ?
			bfmcs_read_mux(reg_address, misc_pin_control, fw_update_enable, mirror) :
			reg_read_data;
	end

	// Control resets to 1Ch so the mezzanine starts enabled, translator off
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			misc_pin_control <= bfmcs_pkg::RST_MISC_PIN_CONTROL;
			fw_update_enable <= bfmcs_pkg::RST_FW_UPDATE_ENABLE;
			reg_read_data    <= 8'h00;
			reg_read_valid   <= 1'b0;
		end else begin
			misc_pin_control <= next_misc_pin_control;
			fw_update_enable <= next_fw_update_enable;
			reg_read_data    <= next_reg_read_data;
			reg_read_valid   <= next_reg_read_valid;
		end
	end

	// ----------------------------------------
	// Control pin outputs
	// ----------------------------------------
	// Straight from register bits, so pins follow the write on the next edge
	assign nand_write_protect          = misc_pin_control[bfmcs_pkg::BIT_NAND_WP];
	assign debug_mezzanine_enable      = misc_pin_control[bfmcs_pkg::BIT_MEZZ_EN];
	assign nor_write_protect           = misc_pin_control[bfmcs_pkg::BIT_NOR_WP];
	assign eeprom_write_protect        = misc_pin_control[bfmcs_pkg::BIT_EEPROM_WP];
	assign i2c_level_translator_enable = misc_pin_control[bfmcs_pkg::BIT_I2C_EN];

	// ----------------------------------------
	// Serial port clock steering
	// ----------------------------------------
	// Clocks pass combinationally: registering them at 40 MHz would alias them
	assign clk_sel = bfmcs_pkg::bfmcs_clk_sel_e'(misc_pin_control[1:0]);

	always_comb begin
		serial_clock_src = backplane_timing_clock_a;
		sport            = '0;
		case (clk_sel)
			bfmcs_pkg::BFMCS_SEL_CLK_A: begin
				serial_clock_src = backplane_timing_clock_a;
				sport.drive_enable = 1'b1;
			end
			bfmcs_pkg::BFMCS_SEL_CLK_B: begin
				serial_clock_src = backplane_timing_clock_b;
				sport.drive_enable = 1'b1;
			end
			bfmcs_pkg::BFMCS_SEL_CLK_D: begin
				serial_clock_src = backplane_timing_clock_d;
				sport.drive_enable = 1'b1;
			end
			bfmcs_pkg::BFMCS_SEL_RELEASE: begin
				sport.drive_enable = 1'b0;
			end
			default: begin
				sport.drive_enable = 1'b0;
			end
		endcase
		if (sport.drive_enable) begin
			sport.sample_clocks        = serial_clock_src;
			sport.transmit_clocks      = serial_clock_src;
			sport.receive_clocks       = serial_clock_src;
			sport.transmit_frame_syncs = backplane_timing_clock_c;
			sport.receive_frame_syncs  = backplane_timing_clock_c;
		end
	end

	// Enable pin is high only in the release setting
	assign backplane_serial_port_enable_n   = ~sport.drive_enable;
	assign serial_port_sample_clocks        = sport.sample_clocks;
	assign serial_port_transmit_clocks      = sport.transmit_clocks;
	assign serial_port_receive_clocks       = sport.receive_clocks;
	assign serial_port_transmit_frame_syncs = sport.transmit_frame_syncs;
	assign serial_port_receive_frame_syncs  = sport.receive_frame_syncs;
	assign serial_port_timing_oe            = sport.drive_enable;

	// ----------------------------------------
	// Firmware-update serial interface mapping
	// ----------------------------------------
	// Only the exact key enables; any other byte leaves GPIOs disconnected
	assign firmware_update_enabled = (fw_update_enable == bfmcs_pkg::FW_UPDATE_KEY);

	always_comb begin
		firmware_update_serial_clock  = 1'b0;
		firmware_update_chip_select_n = 1'b1;
		firmware_update_serial_out    = 1'b0;
		firmware_update_serial_oe     = 1'b0;
		processor_gpio_out            = 4'h0;
		processor_gpio_oe             = 4'h0;
		if (firmware_update_enabled) begin
			firmware_update_serial_clock  = processor_gpio_in[0];
			firmware_update_chip_select_n = processor_gpio_in[1];
			firmware_update_serial_out    = processor_gpio_in[2];
			firmware_update_serial_oe     = 1'b1;
			processor_gpio_out[3]         = firmware_update_serial_in;
			processor_gpio_oe[3]          = 1'b1;
		end
	end
endmodule : bfmcs_misc_regs
`default_nettype wire

// ### bench/bfmcs_misc_assertions.sv
// Concurrent checks on the misc control and status register block ports
`timescale 1ns/1ps
`default_nettype none
module bfmcs_misc_assertions (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic [7:0] reg_address,
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_write_data,
	input wire logic [7:0] reg_read_data,
	input wire logic       reg_read_valid,
	input wire logic       processor_reset_status_n,
	input wire logic       trigger_reset_n,
	input wire logic       pcie_subsystem_enable_switch,
	input wire logic       user_board_switch,
	input wire logic       processor_host_output,
	input wire logic       processor_system_clock_output,
	input wire logic       backplane_serial_port_enable_n,
	input wire logic       nand_write_protect,
	input wire logic       debug_mezzanine_enable,
	input wire logic       nor_write_protect,
	input wire logic       eeprom_write_protect,
	input wire logic       i2c_level_translator_enable,
	input wire logic       backplane_timing_clock_c,
	input wire logic       serial_port_sample_clocks,
	input wire logic       serial_port_transmit_clocks,
	input wire logic       serial_port_receive_clocks,
	input wire logic       serial_port_transmit_frame_syncs,
	input wire logic       serial_port_receive_frame_syncs,
	input wire logic       serial_port_timing_oe,
	input wire logic [3:0] processor_gpio_in,
	input wire logic [3:0] processor_gpio_out,
	input wire logic       firmware_update_serial_clock,
	input wire logic       firmware_update_chip_select_n,
	input wire logic       firmware_update_serial_out,
	input wire logic       firmware_update_serial_in,
	input wire logic       firmware_update_enabled
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic [1:0] age;
	wire  [4:0] pins = {i2c_level_translator_enable, eeprom_write_protect, nor_write_protect,
		debug_mezzanine_enable, nand_write_protect};
	// Edges since reset; synchroniser checks wait until no stage still holds reset zeros
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end
	a_read_valid: assert property (reg_read |=> reg_read_valid)
		else $error("read strobe without valid");
	a_reset_pins: assert property ($fell(reset) |-> pins == 5'h07 && !backplane_serial_port_enable_n)
		else $error("control outputs wrong after reset");
	a_write_pins: assert property (reg_write && reg_address == 8'h0C |=> pins == $past(reg_write_data[6:2]))
		else $error("control write not on pins");
	a_ctrl_read: assert property (reg_read && reg_address == 8'h0C |=> reg_read_data[7:2] == {1'b0, $past(pins)})
		else $error("control readback wrong");
	a_release_oe: assert property (backplane_serial_port_enable_n == !serial_port_timing_oe)
		else $error("enable pin and output enable disagree");
	a_syncs_clock_c: assert property (serial_port_timing_oe |-> serial_port_transmit_frame_syncs == backplane_timing_clock_c && serial_port_receive_frame_syncs == backplane_timing_clock_c)
		else $error("frame syncs not from clock C");
	a_clocks_alike: assert property (serial_port_sample_clocks == serial_port_transmit_clocks && serial_port_transmit_clocks == serial_port_receive_clocks)
		else $error("serial clocks differ");
	a_fw_key: assert property (reg_write && reg_address == 8'h0E |=> firmware_update_enabled == ($past(reg_write_data) == 8'h68))
		else $error("update enable does not follow key");
	a_fw_hold: assert property (!(reg_write && reg_address == 8'h0E) |=> $stable(firmware_update_enabled))
		else $error("update enable changed without write");
	a_gpio_map: assert property (firmware_update_enabled |-> {firmware_update_serial_out, firmware_update_chip_select_n, firmware_update_serial_clock} == processor_gpio_in[2:0] && processor_gpio_out[3] == firmware_update_serial_in)
		else $error("gpio mapping wrong while enabled");
	a_status_b: assert property (age == 2'h3 && reg_read && reg_address == 8'h0B |=> reg_read_data == {$past({user_board_switch, pcie_subsystem_enable_switch, trigger_reset_n, processor_reset_status_n}, 3), 4'h0})
		else $error("status 0B readback wrong");
	a_status_d: assert property (age == 2'h3 && reg_read && reg_address == 8'h0D |=> reg_read_data == {4'h0, $past({processor_system_clock_output, processor_host_output}, 3), 1'b0, $past(firmware_update_enabled)})
		else $error("status 0D readback wrong");
	c_fw_key: cover property (reg_write && reg_address == 8'h0E && reg_write_data == 8'h68);
	c_released: cover property (!serial_port_timing_oe);
	c_status_read: cover property (reg_read && reg_address == 8'h0D && firmware_update_enabled);
endmodule : bfmcs_misc_assertions
`default_nettype wire

// ### bench/bfmcs_board_model.sv
// Board-side model: free-running backplane timing clocks and update flash data line
`timescale 1ns/1ps
`default_nettype none
module bfmcs_board_model (
	input  wire logic serial_clock,
	input  wire logic serial_out,
	output logic      clk_a,
	output logic      clk_b,
	output logic      clk_c,
	output logic      clk_d,
	output logic      serial_in
);
	// Whole-ns half periods never meet the bench's half-ns rising edges, but can meet its whole-ns falling-edge checks
	initial begin
		clk_a = 1'b0;
		clk_b = 1'b1;
		clk_c = 1'b0;
		clk_d = 1'b1;
		serial_in = 1'b0;
		fork
			forever #17 clk_a = ~clk_a;
			forever #22 clk_b = ~clk_b;
			forever #27 clk_c = ~clk_c;
			forever #31 clk_d = ~clk_d;
		join
	end
	// Flash answers with the inverse of the last bit shifted in
	always @(posedge serial_clock) serial_in <= ~serial_out;
endmodule : bfmcs_board_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the misc control and status register block
`timescale 1ns/1ps
`default_nettype none
bind bfmcs_misc_regs bfmcs_misc_assertions chk_i (.clk, .reset, .reg_address, .reg_write,
	.reg_read, .reg_write_data, .reg_read_data, .reg_read_valid, .processor_reset_status_n,
	.trigger_reset_n, .pcie_subsystem_enable_switch, .user_board_switch, .processor_host_output,
	.processor_system_clock_output, .backplane_serial_port_enable_n, .nand_write_protect,
	.debug_mezzanine_enable, .nor_write_protect, .eeprom_write_protect,
	.i2c_level_translator_enable, .backplane_timing_clock_c, .serial_port_sample_clocks,
	.serial_port_transmit_clocks, .serial_port_receive_clocks, .serial_port_transmit_frame_syncs,
	.serial_port_receive_frame_syncs, .serial_port_timing_oe, .processor_gpio_in,
	.processor_gpio_out, .firmware_update_serial_clock, .firmware_update_chip_select_n,
	.firmware_update_serial_out, .firmware_update_serial_in, .firmware_update_enabled);
module testbench;
	logic                     clk, reset, wr_s, rd_s, valid;
	logic [7:0]               addr, wdata, rdata;
	logic [3:0]               gpio_in, gpio_out, gpio_oe;
	logic                     ca, cb, cc, cd, fclk, fcs_n, fout, foe, fin, fen;
	logic                     en_n, nand_wp, mezz, nor_wp, ee_wp, i2c, sc, tc, rc, tf, rf, oe;
	bfmcs_pkg::bfmcs_mirror_s mir;
	int                       n_mismatch = 0, checks = 0;
	// Rows: written byte, expected readback, expected enable pin level
	logic [16:0]              rows [8] = '{{8'h00, 8'h00, 1'b0}, {8'h01, 8'h01, 1'b0},
		{8'h02, 8'h02, 1'b0}, {8'h03, 8'h03, 1'b1}, {8'hFF, 8'h7F, 1'b1}, {8'h80, 8'h00, 1'b0},
		{8'h54, 8'h54, 1'b0}, {8'h2B, 8'h2B, 1'b1}};
	bfmcs_pkg::bfmcs_mirror_s pats [2] = '{6'h2A, 6'h15};
	logic [3:0]               gps [2] = '{4'h5, 4'hA};
	bfmcs_misc_regs uut (.clk(clk), .reset(reset), .reg_address(addr), .reg_write(wr_s),
		.reg_read(rd_s), .reg_write_data(wdata), .reg_read_data(rdata), .reg_read_valid(valid),
		.processor_reset_status_n(mir.processor_reset_status_n),
		.trigger_reset_n(mir.trigger_reset_n), .user_board_switch(mir.user_board_switch),
		.pcie_subsystem_enable_switch(mir.pcie_subsystem_enable_switch),
		.processor_host_output(mir.processor_host_output),
		.processor_system_clock_output(mir.processor_system_clock_output),
		.backplane_serial_port_enable_n(en_n), .nand_write_protect(nand_wp),
		.debug_mezzanine_enable(mezz), .nor_write_protect(nor_wp), .eeprom_write_protect(ee_wp),
		.i2c_level_translator_enable(i2c), .backplane_timing_clock_a(ca),
		.backplane_timing_clock_b(cb), .backplane_timing_clock_c(cc),
		.backplane_timing_clock_d(cd), .serial_port_sample_clocks(sc),
		.serial_port_transmit_clocks(tc), .serial_port_receive_clocks(rc),
		.serial_port_transmit_frame_syncs(tf), .serial_port_receive_frame_syncs(rf),
		.serial_port_timing_oe(oe), .processor_gpio_in(gpio_in), .processor_gpio_out(gpio_out),
		.processor_gpio_oe(gpio_oe), .firmware_update_serial_clock(fclk),
		.firmware_update_chip_select_n(fcs_n), .firmware_update_serial_out(fout),
		.firmware_update_serial_oe(foe), .firmware_update_serial_in(fin),
		.firmware_update_enabled(fen));
	bfmcs_board_model board (.serial_clock(fclk), .serial_out(fout), .clk_a(ca), .clk_b(cb),
		.clk_c(cc), .clk_d(cd), .serial_in(fin));
	// ----------------------------------------
	// Clock, shared checks and bus cycles
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	// One-cycle strobes launched at the falling edge, so the rising edge sees them settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		@(negedge clk);
		wr_s = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge clk);
		addr = a;
		rd_s = 1'b1;
		@(negedge clk);
		rd_s = 1'b0;
		chk("read_valid", {7'h0, valid}, 8'h01);
		chk(what, rdata, exp);
	endtask : rd
	function automatic logic pick(input logic [1:0] s);
		return (s == 2'b00) ? ca : (s == 2'b01) ? cb : cd;
	endfunction : pick
	// Hang guard, far beyond the roughly 104 cycles the sequence needs
	initial begin
		#20000;
		n_mismatch++;
		stop_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{reset, wr_s, rd_s, addr, wdata, gpio_in, mir} = {1'b1, 28'h0};
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		foreach (rows[i]) begin
			wr(8'h0C, rows[i][16:9]);
			rd(8'h0C, rows[i][8:1], "ctrl");
			chk("pins", {3'h0, i2c, ee_wp, nor_wp, mezz, nand_wp}, {3'h0, rows[i][7:3]});
			chk("enable", {6'h0, en_n, oe}, {6'h0, rows[i][0], ~rows[i][0]});
			repeat (3) begin
				@(negedge clk);
				chk("steer", {3'h0, sc, tc, rc, tf, rf}, rows[i][0] ? 8'h00 :
					{3'h0, {3{pick(rows[i][2:1])}}, cc, cc});
			end
		end
		// Second reset in mid-run restores every default
		@(negedge clk);
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		rd(8'h0C, 8'h1C, "ctrl_reset");
		chk("pins_reset", {3'h0, i2c, ee_wp, nor_wp, mezz, nand_wp}, 8'h07);
		rd(8'h0E, 8'h00, "fw_reset");
		// Read and write in one cycle: the read returns the old byte
		@(negedge clk);
		{addr, wdata, wr_s, rd_s} = {8'h0C, 8'h00, 2'b11};
		@(negedge clk);
		{wr_s, rd_s} = 2'b00;
		chk("rw_old", rdata, 8'h1C);
		rd(8'h0C, 8'h00, "rw_new");
		// Mirrored levels, with writes to read-only offsets ignored
		foreach (pats[i]) begin
			@(negedge clk);
			mir = pats[i];
			wr(8'h0B, 8'hFF);
			wr(8'h0D, 8'hFF);
			rd(8'h0B, {mir[3:0], 4'h0}, "status_b");
			rd(8'h0D, {4'h0, mir[5:4], 2'b00}, "status_d");
		end
		wr(8'h0E, 8'h68);
		rd(8'h0D, {4'h0, mir[5:4], 2'b01}, "fw_status");
		foreach (gps[i]) begin
			@(negedge clk);
			gpio_in = gps[i];
			#1;
			chk("gpio_map", {4'h0, fout, fcs_n, fclk, fen}, {4'h0, gps[i][2:0], 1'b1});
			chk("gpio_back", {gpio_oe, gpio_out}, {4'h8, fin, 3'h0});
		end
		wr(8'h0E, 8'h69);
		rd(8'h0E, 8'h69, "fw_reg");
		chk("fw_off", {6'h0, fcs_n, fen}, 8'h02);
		wr(8'h20, 8'hFF);
		rd(8'h20, 8'h00, "unmapped");
		stop_test();
	end
endmodule : testbench
`default_nettype wire
